// >>> design/ras_pkg.sv
package ras_pkg;

   // Bus identity and address space limits
   localparam logic [6:0] SLAVE_ADDR = 7'h36;
   localparam logic [7:0] WR_LIMIT = 8'h4f;
   localparam logic [7:0] FUNCTION_COMMAND_BYTE_ADDR = 8'hfe;
   localparam logic [7:0] BYTE_PAST_END = 8'hff;
   localparam logic [7:0] RESERVED_READ = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Register locations
   localparam logic [7:0] STATUS_ADDR = 8'h01;
   localparam logic [7:0] MEAS_FIRST = 8'h08;
   localparam logic [7:0] MEAS_LAST = 8'h0f;
   localparam logic [7:0] ACC_MSB_ADDR = 8'h10;
   localparam logic [7:0] ACC_LSB_ADDR = 8'h11;
   localparam logic [7:0] OFFS_BIAS_ADDR = 8'h61;
   localparam logic [7:0] ACC_BIAS_ADDR = 8'h62;

   // Shadow RAM blocks of the nonvolatile array, each with its own lock
   localparam logic [7:0] NV_BLK0_BASE = 8'h20;
   localparam logic [7:0] NV_BLK1_BASE = 8'h30;
   localparam logic [7:0] NV_BLK_LAST_OFS = 8'h0f;

   // Status/config layout: bits 6..3 writable, 7 and 2 reserved, 1..0 live
   localparam logic [7:0] STATUS_RST = 8'h70;
   localparam logic [7:0] STATUS_WR_MASK = 8'h78;
   localparam logic [7:0] FULL_MASK = 8'hff;
   localparam logic [7:0] NO_MASK = 8'h00;

   // Measurement words, most significant byte at the even address
   typedef struct packed {
      logic [15:0] aux0;
      logic [15:0] aux1;
      logic [15:0] volt;
      logic [15:0] curr;
   } ras_meas_t;

   // Committed byte, one-cycle valid
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } ras_wr_t;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_ADDR      = 9'h002,
      ST_ADDR_ACK  = 9'h004,
      ST_PTR       = 9'h008,
      ST_PTR_ACK   = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RACK      = 9'h100
   } ras_state_t;

endpackage

// >>> design/ras_sync.sv
`timescale 1ns/100ps
module ras_sync #(
   parameter int W = 1
) (
   sys_clk, // System clock
   nrst,    // Asynchronous reset, active low
   async_i, // Levels from another domain
   sync_o   // Filtered levels
);
   input wire logic sys_clk;
   input wire logic nrst;
   input wire logic [W-1:0] async_i;
   output logic [W-1:0] sync_o;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } ras_sync_st_t;

   ras_sync_st_t q, d;

   // A bit only moves once stages two and three agree; stage one feeds stage two alone
   always_comb begin
      d = q;
      d.s1 = async_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.out[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.out;

endmodule

// >>> design/ras_link_cap.sv
`timescale 1ns/100ps
module ras_link_cap (
   scl_clk, // Serial clock from the master
   nrst,    // Asynchronous reset, active low
   sda_i,   // Data line level
   bit_o,   // Bit taken at the last rising edge
   tgl_o    // Toggles once per rising edge
);
   input wire logic scl_clk;
   input wire logic nrst;
   input wire logic sda_i;
   output logic bit_o;
   output logic tgl_o;

   typedef struct packed {
      logic bit_q;
      logic tgl_q;
   } ras_cap_st_t;

   ras_cap_st_t q, d;

   // Bit stays put a whole clock period, so the toggle alone needs synchronising
   always_comb begin
      d = q;
      d.bit_q = sda_i;
      d.tgl_q = ~q.tgl_q;
   end

   always_ff @(posedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bit_o = q.bit_q;
   assign tgl_o = q.tgl_q;

endmodule

// >>> design/ras_slave.sv
`timescale 1ns/100ps
module ras_slave #(
   parameter logic [6:0] DEV_ADDR = ras_pkg::SLAVE_ADDR,
   parameter logic [7:0] WRITE_LIMIT = ras_pkg::WR_LIMIT
) (
   sys_clk,    // System clock, 100 MHz
   nrst,       // Asynchronous reset, active low
   scl_clk,    // Serial clock pin, clocks the bit capture
   sda_i,      // Data line level
   sda_o,      // Data line drive level, always low
   sda_oe,     // Data line pull-down enable
   meas_i,     // Measurement words served read-only
   ain_ok_i,   // Conversion valid flags shown in the status byte
   nv_lock_i,  // Lock of the two nonvolatile blocks
   status_o,   // Status/config byte as stored
   wr_o,       // Byte committed to storage
   function_command_byte_o      // Function command byte received
);
   input wire logic sys_clk;
   input wire logic nrst;
   input wire logic scl_clk;
   input wire logic sda_i;
   output logic sda_o;
   output logic sda_oe;
   input wire ras_pkg::ras_meas_t meas_i;
   input wire logic [1:0] ain_ok_i;
   input wire logic [1:0] nv_lock_i;
   output logic [7:0] status_o;
   output ras_pkg::ras_wr_t wr_o;
   output ras_pkg::ras_wr_t function_command_byte_o;

   typedef logic [255:0][7:0] ras_mem_t;

   typedef struct packed {
      ras_pkg::ras_state_t state;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic ack_on;
      logic first;
      logic past_end;
      logic [7:0] ptr;
      logic [7:0] tx;
      logic [7:0] pend_addr;
      logic [7:0] pend_data;
      logic pend_fc;
      logic pend_beyond;
      logic scl_p;
      logic sda_p;
      logic tgl_p;
      logic drv_lvl;
      logic oe;
      ras_pkg::ras_wr_t wr;
      ras_pkg::ras_wr_t function_command_byte;
      ras_mem_t mem;
   } ras_st_t;

   ras_st_t q, d;
   logic cap_bit;
   logic cap_tgl;
   logic [2:0] lvl_f;
   logic scl_f;
   logic sda_f;
   logic tgl_f;

   // Serial clock domain: one bit per rising edge, flagged by a toggle
   ras_link_cap u_cap (
      .scl_clk(scl_clk),
      .nrst(nrst),
      .sda_i(sda_i),
      .bit_o(cap_bit),
      .tgl_o(cap_tgl)
   );

   // Line levels and the toggle enter the system domain through three stages
   ras_sync #(
      .W(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .async_i({scl_clk, sda_i, cap_tgl}),
      .sync_o(lvl_f)
   );

   assign scl_f = lvl_f[2];
   assign sda_f = lvl_f[1];
   assign tgl_f = lvl_f[0];

   // Byte seen by the master at a location; reserved space reads zero
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input ras_mem_t m,
                                          input ras_pkg::ras_meas_t meas,
                                          input logic [1:0] ain);
      logic [15:0] word;
      word = '0;
      rd_byte = ras_pkg::RESERVED_READ;
      if (a == ras_pkg::STATUS_ADDR) begin
         rd_byte = {1'b0, m[a][6:3], 1'b0, ain};
      end else if (a >= ras_pkg::MEAS_FIRST && a <= ras_pkg::MEAS_LAST) begin
         case (a[2:1])
            2'h0: word = meas.aux0;
            2'h1: word = meas.aux1;
            2'h2: word = meas.volt;
            default: word = meas.curr;
         endcase
         rd_byte = a[0] ? word[7:0] : word[15:8];
      end else if (wr_mask(a, 2'h0) != ras_pkg::NO_MASK) begin
         rd_byte = m[a];
      end
   endfunction

   // Writable bits of a location; zero means the byte is dropped
   function automatic logic [7:0] wr_mask(input logic [7:0] a, input logic [1:0] lock);
      wr_mask = ras_pkg::NO_MASK;
      if (a == ras_pkg::STATUS_ADDR) begin
         wr_mask = ras_pkg::STATUS_WR_MASK;
      end else if (a == ras_pkg::ACC_MSB_ADDR || a == ras_pkg::ACC_LSB_ADDR ||
                   a == ras_pkg::OFFS_BIAS_ADDR || a == ras_pkg::ACC_BIAS_ADDR) begin
         wr_mask = ras_pkg::FULL_MASK;
      end else if (a >= ras_pkg::NV_BLK0_BASE && !lock[0] &&
                   a <= ras_pkg::NV_BLK0_BASE + ras_pkg::NV_BLK_LAST_OFS) begin
         wr_mask = ras_pkg::FULL_MASK;
      end else if (a >= ras_pkg::NV_BLK1_BASE && !lock[1] &&
                   a <= ras_pkg::NV_BLK1_BASE + ras_pkg::NV_BLK_LAST_OFS) begin
         wr_mask = ras_pkg::FULL_MASK;
      end
   endfunction

   // Protocol engine, stepped by serial clock edges seen in this domain
   always_comb begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic [7:0] nb;
      logic [7:0] nptr;
      logic [7:0] mask;
      logic beyond;
      rise = (tgl_f != q.tgl_p);
      fall = q.scl_p & ~scl_f;
      start = scl_f & q.scl_p & q.sda_p & ~sda_f;
      stop = scl_f & q.scl_p & ~q.sda_p & sda_f;
      nb = {q.sh[6:0], cap_bit};
      nptr = q.ptr + 8'h01;
      mask = wr_mask(q.pend_addr, nv_lock_i);
      beyond = q.past_end | (~q.first & (q.ptr > WRITE_LIMIT));
      d = q;
      d.scl_p = scl_f;
      d.sda_p = sda_f;
      d.tgl_p = tgl_f;
      d.wr.valid = 1'b0;
      d.function_command_byte.valid = 1'b0;
      if (stop) begin
         d.state = ras_pkg::ST_IDLE;
         d.oe = 1'b0;
      end else if (start) begin
         d.state = ras_pkg::ST_ADDR;
         d.cnt = '0;
         d.oe = 1'b0;
         d.past_end = 1'b0;
      end else begin
         case (q.state)
            ras_pkg::ST_IDLE: begin
               d.oe = 1'b0;
            end
            ras_pkg::ST_ADDR: begin
               if (rise) begin
                  d.sh = nb;
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == ras_pkg::BIT_LAST) begin
                     d.ack_on = 1'b0;
                     d.rw = nb[0];
                     d.tx = q.past_end ? ras_pkg::BYTE_PAST_END :
                            rd_byte(q.ptr, q.mem, meas_i, ain_ok_i);
                     if (nb[7:1] == DEV_ADDR) begin
                        d.state = ras_pkg::ST_ADDR_ACK;
                     end else begin
                        d.state = ras_pkg::ST_IDLE;
                     end
                  end
               end
            end
            ras_pkg::ST_ADDR_ACK: begin
               if (fall) begin
                  if (!q.ack_on) begin
                     d.ack_on = 1'b1;
                     d.oe = 1'b1;
                  end else begin
                     d.ack_on = 1'b0;
                     d.cnt = '0;
                     if (q.rw) begin
                        d.state = ras_pkg::ST_RDATA;
                        d.oe = ~q.tx[7];
                     end else begin
                        d.state = ras_pkg::ST_PTR;
                        d.oe = 1'b0;
                     end
                  end
               end
            end
            ras_pkg::ST_PTR: begin
               if (rise) begin
                  d.sh = nb;
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == ras_pkg::BIT_LAST) begin
                     d.ptr = nb;
                     d.first = 1'b1;
                     d.past_end = 1'b0;
                     d.ack_on = 1'b0;
                     d.state = ras_pkg::ST_PTR_ACK;
                  end
               end
            end
            ras_pkg::ST_PTR_ACK: begin
               if (fall) begin
                  if (!q.ack_on) begin
                     d.ack_on = 1'b1;
                     d.oe = 1'b1;
                  end else begin
                     d.ack_on = 1'b0;
                     d.cnt = '0;
                     d.oe = 1'b0;
                     d.state = ras_pkg::ST_WDATA;
                  end
               end
            end
            ras_pkg::ST_WDATA: begin
               d.oe = 1'b0;
               if (rise) begin
                  d.sh = nb;
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == ras_pkg::BIT_LAST) begin
                     d.pend_addr = q.ptr;
                     d.pend_data = nb;
                     d.pend_beyond = beyond;
                     d.pend_fc = q.first & (q.ptr == ras_pkg::FUNCTION_COMMAND_BYTE_ADDR);
                     d.past_end = beyond;
                     d.first = 1'b0;
                     d.ptr = nptr;
                     d.ack_on = 1'b0;
                     d.state = ras_pkg::ST_WDATA_ACK;
                  end
               end
            end
            ras_pkg::ST_WDATA_ACK: begin
               // Storage changes only at the acknowledge clock we drove
               if (rise && q.oe) begin
                  if (q.pend_fc) begin
                     d.function_command_byte.valid = 1'b1;
                     d.function_command_byte.addr = q.pend_addr;
                     d.function_command_byte.data = q.pend_data;
                  end else if (!q.pend_beyond && q.pend_addr != ras_pkg::FUNCTION_COMMAND_BYTE_ADDR &&
                               mask != ras_pkg::NO_MASK) begin
                     d.mem[q.pend_addr] = (q.mem[q.pend_addr] & ~mask) |
                                          (q.pend_data & mask);
                     d.wr.valid = 1'b1;
                     d.wr.addr = q.pend_addr;
                     d.wr.data = q.pend_data;
                  end
               end
               if (fall) begin
                  if (!q.ack_on) begin
                     d.ack_on = 1'b1;
                     d.oe = 1'b1;
                  end else begin
                     d.ack_on = 1'b0;
                     d.cnt = '0;
                     d.oe = 1'b0;
                     d.state = ras_pkg::ST_WDATA;
                  end
               end
            end
            ras_pkg::ST_RDATA: begin
               if (rise) begin
                  d.tx = {q.tx[6:0], 1'b1};
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == ras_pkg::BIT_LAST) begin
                     d.ptr = nptr;
                     d.past_end = q.past_end | (q.ptr == ras_pkg::BYTE_PAST_END);
                     if (q.past_end || q.ptr == ras_pkg::BYTE_PAST_END) begin
                        d.tx = ras_pkg::BYTE_PAST_END;
                     end else begin
                        d.tx = rd_byte(nptr, q.mem, meas_i, ain_ok_i);
                     end
                     d.ack_on = 1'b0;
                     d.state = ras_pkg::ST_RACK;
                  end
               end else if (fall) begin
                  d.oe = ~q.tx[7];
               end
            end
            ras_pkg::ST_RACK: begin
               if (fall) begin
                  if (!q.ack_on) begin
                     d.oe = 1'b0;
                  end else begin
                     d.ack_on = 1'b0;
                     d.cnt = '0;
                     d.oe = ~q.tx[7];
                     d.state = ras_pkg::ST_RDATA;
                  end
               end else if (rise) begin
                  if (cap_bit) begin
                     d.state = ras_pkg::ST_IDLE;
                     d.oe = 1'b0;
                  end else begin
                     d.ack_on = 1'b1;
                  end
               end
            end
            default: begin
               d.state = ras_pkg::ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
   end

   // Whole engine in one register; the status byte starts at its power-up value
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.state <= ras_pkg::ST_IDLE;
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
         q.mem[ras_pkg::STATUS_ADDR] <= ras_pkg::STATUS_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs taken straight from the register; the pin only ever pulls low
   assign sda_o = q.drv_lvl;
   assign sda_oe = q.oe;
   assign status_o = q.mem[ras_pkg::STATUS_ADDR];
   assign wr_o = q.wr;
   assign function_command_byte_o = q.function_command_byte;

endmodule

// >>> verification/ras_i2c_master.sv
`timescale 1ns/100ps
// Bus master model: makes the serial clock and pulls the open-drain data line
module ras_i2c_master (
   output logic scl,   // Serial clock, still between frames
   output logic pull,  // High while the master pulls the data line low
   input wire logic sda // Resolved data line level
);
   // Base tick of a tenth of the 400 ns link period; low phase stretched for the sync delay
   localparam int T = 40;

   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end

   // Start or repeated start; data released first so it also serves from a low clock
   task automatic start();
      #3.3 pull = 1'b0;
      #(5*T) scl = 1'b1;
      #(4*T) pull = 1'b1;
      #(4*T) scl = 1'b0;
   endtask

   // Stop ends every frame, also after a partial byte
   task automatic stop();
      #T pull = 1'b1;
      #(5*T) scl = 1'b1;
      #(4*T) pull = 1'b0;
      #(4*T);
   endtask

   // One clock pulse; data set well after the fall, line sampled at the rise
   task automatic bit_x(input logic b, output logic s);
      #T pull = !b;
      #(5*T) scl = 1'b1;
      s = sda;
      #(4*T) scl = 1'b0;
   endtask

   // Sends n bits msb first, then samples the acknowledge for a whole byte
   task automatic send(input logic [7:0] d, input int n, output logic ack);
      logic s;
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) bit_x(d[i], s);
      if (n == 8) begin
         bit_x(1'b1, s);
         ack = !s;
      end
   endtask

   // Takes one byte and answers it; a no-acknowledge hands the line back
   task automatic recv(input logic nak, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(nak, s);
   endtask
endmodule

// >>> verification/ras_slave_properties.sv
`timescale 1ns/100ps
// Port-level checks of the register access slave
module ras_chk #(
   parameter logic [6:0] DEV_ADDR = ras_pkg::SLAVE_ADDR,
   parameter logic [7:0] WRITE_LIMIT = ras_pkg::WR_LIMIT
) (
   input wire logic sys_clk,               // System clock
   input wire logic nrst,                  // Reset, active low
   input wire logic scl_clk,               // Serial clock pin
   input wire logic sda_i,                 // Data line level
   input wire logic sda_o,                 // Drive level
   input wire logic sda_oe,                // Pull-down enable
   input wire ras_pkg::ras_meas_t meas_i,  // Measurements
   input wire logic [1:0] ain_ok_i,        // Conversion flags
   input wire logic [1:0] nv_lock_i,       // Block locks
   input wire logic [7:0] status_o,        // Stored status
   input wire ras_pkg::ras_wr_t wr_o,      // Commits
   input wire ras_pkg::ras_wr_t function_command_byte_o     // Commands
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // Places that may ever take a byte; 61h/62h only as the first byte of a write
   function automatic logic may_store(logic [7:0] a, logic [1:0] lk);
      return a == ras_pkg::STATUS_ADDR || a == ras_pkg::ACC_MSB_ADDR
         || a == ras_pkg::ACC_LSB_ADDR || a == ras_pkg::OFFS_BIAS_ADDR
         || a == ras_pkg::ACC_BIAS_ADDR || (a[7:4] == 4'h2 && !lk[0] && a <= WRITE_LIMIT)
         || (a[7:4] == 4'h3 && !lk[1] && a <= WRITE_LIMIT);
   endfunction

   // Commit, then the clock fall that closes its acknowledge slot
   sequence s_commit_fall;
      wr_o.valid ##[1:30] $fell(scl_clk);
   endsequence
   property p_release_after_ack;
      first_match(s_commit_fall) |-> ##[1:8] !sda_oe;
   endproperty

   a_reset_values: assert property ($rose(nrst) |-> status_o == ras_pkg::STATUS_RST && !sda_oe)
      else $error("state after reset wrong");
   a_commit_pulse: assert property (wr_o.valid |=> !wr_o.valid)
      else $error("commit pulse longer than one cycle");
   a_commit_place: assert property (wr_o.valid |-> may_store(wr_o.addr, nv_lock_i))
      else $error("byte committed to a protected place");
   a_commit_acked: assert property (wr_o.valid |-> sda_oe && scl_clk)
      else $error("commit outside an acknowledge slot");
   a_status_write: assert property (wr_o.valid && wr_o.addr == ras_pkg::STATUS_ADDR
      |-> status_o == (wr_o.data & ras_pkg::STATUS_WR_MASK))
      else $error("status bits stored wrongly");
   a_status_hold: assert property ($changed(status_o)
      |-> wr_o.valid && wr_o.addr == ras_pkg::STATUS_ADDR)
      else $error("status changed without a commit");
   a_function_command_byte_place: assert property (function_command_byte_o.valid
      |-> function_command_byte_o.addr == ras_pkg::FUNCTION_COMMAND_BYTE_ADDR && !wr_o.valid ##1 !function_command_byte_o.valid)
      else $error("command pulse wrong");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_clk && !$past(scl_clk))
      else $error("data drive changed while clock high");
   a_ack_release: assert property (p_release_after_ack)
      else $error("acknowledge not released after the slot");
   a_drive_level: assert property (sda_oe |-> !sda_o)
      else $error("data line driven high");
endmodule

bind ras_slave ras_chk #(.DEV_ADDR(DEV_ADDR), .WRITE_LIMIT(WRITE_LIMIT)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .scl_clk(scl_clk), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .meas_i(meas_i), .ain_ok_i(ain_ok_i),
   .nv_lock_i(nv_lock_i), .status_o(status_o), .wr_o(wr_o), .function_command_byte_o(function_command_byte_o)
);

// >>> verification/testbench.sv
`timescale 1ns/100ps
// Reference model of the register space compared with the slave at every result
module testbench;
   logic sys_clk;
   logic nrst;
   logic [1:0] lock;
   logic [1:0] ain;
   ras_pkg::ras_meas_t meas;
   logic sda_o;
   logic sda_oe;
   logic scl;
   logic pull;
   logic sda;
   logic [7:0] status;
   ras_pkg::ras_wr_t wr;
   ras_pkg::ras_wr_t function_command_byte;
   int errors;
   int compares;
   int function_command_byte_n;
   int fexp;
   int mem [256];
   logic [31:0] seed;
   logic [15:0] exp_q [$];
   logic [15:0] got_q [$];

   // Open-drain wire with pull-up
   assign sda = !(pull || sda_oe);

   ras_i2c_master m (.scl(scl), .pull(pull), .sda(sda));

   ras_slave dut (
      .sys_clk(sys_clk), .nrst(nrst), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .meas_i(meas), .ain_ok_i(ain), .nv_lock_i(lock),
      .status_o(status), .wr_o(wr), .function_command_byte_o(function_command_byte)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = !sys_clk;
   end

   // Commits seen; status data masked since only its writable bits are defined
   always @(posedge sys_clk) begin
      if (wr.valid === 1'b1)
         got_q.push_back({wr.addr, wr.addr == 8'h01 ? wr.data & 8'h78 : wr.data});
      if (function_command_byte.valid === 1'b1)
         function_command_byte_n++;
   end

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   // 0 reserved, 1 storage, 2 status, 3 measurement
   function automatic int kind(int a);
      if (a == 8'h01) return 2;
      if (a >= 8'h08 && a <= 8'h0f) return 3;
      if (a == 8'h10 || a == 8'h11 || a == 8'h61 || a == 8'h62) return 1;
      return (a >= 8'h20 && a <= 8'h3f) ? 1 : 0;
   endfunction

   // Expected read value; -1 where the content is undefined or never written
   function automatic int exp_rd(int a);
      if (a > 8'hff) return 8'hff;
      if (kind(a) == 2) return {1'b0, mem[1][6:3], 1'b0, ain};
      if (kind(a) == 3) return meas[8*(15-a) +: 8];
      return kind(a) == 1 ? mem[a] : -1;
   endfunction

   task automatic init_model();
      foreach (mem[i]) mem[i] = -1;
      mem[1] = 8'h70;
      mem[8'h61] = 0;
      mem[8'h62] = 0;
   endtask

   // Model of one written byte
   task automatic mwr(int a, bit first, logic [7:0] d);
      if (first && a == 8'hfe) fexp++;
      if ((!first && a > 8'h4f) || kind(a) == 0 || kind(a) == 3) return;
      if (((a >> 4) == 2 && lock[0]) || ((a >> 4) == 3 && lock[1])) return;
      if (a == 1) d = d & 8'h78;
      mem[a] = d;
      exp_q.push_back({a[7:0], d});
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Drains both commit queues in order
   task automatic cmp_commits();
      repeat (10) @(negedge sys_clk);
      cmp(16'(got_q.size()), 16'(exp_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0)
         cmp(got_q.pop_front(), exp_q.pop_front());
      got_q.delete();
      exp_q.delete();
      cmp(16'(function_command_byte_n), 16'(fexp));
   endtask

   task automatic probe(logic [6:0] id, logic ok);
      logic a;
      m.start();
      m.send({id, 1'b0}, 8, a);
      cmp(16'(a), 16'(ok));
      m.send(8'h01, 8, a);
      cmp(16'(a), 16'(ok));
      m.stop();
   endtask

   // Write of n random bytes from p; nb below 8 cuts the last byte short
   task automatic wseq(int p, int n, int nb);
      logic a;
      logic [7:0] d;
      m.start();
      m.send({ras_pkg::SLAVE_ADDR, 1'b0}, 8, a);
      m.send(p[7:0], 8, a);
      cmp(16'(a), 16'h1);
      for (int i = 0; i < n; i++) begin
         d = rnd();
         m.send(d, i == n - 1 ? nb : 8, a);
         if (i < n - 1 || nb == 8) cmp(16'(a), 16'h1);
         if (i < n - 1 || nb == 8) mwr(p + i, i == 0, d);
      end
      m.stop();
      cmp_commits();
   endtask

   task automatic rseq(int p, int n);
      logic a;
      logic [7:0] d;
      int e;
      m.start();
      m.send({ras_pkg::SLAVE_ADDR, 1'b0}, 8, a);
      m.send(p[7:0], 8, a);
      m.start();
      m.send({ras_pkg::SLAVE_ADDR, 1'b1}, 8, a);
      cmp(16'(a), 16'h1);
      for (int i = 0; i < n; i++) begin
         m.recv(i == n - 1, d);
         e = exp_rd(p + i);
         if (e >= 0) cmp(16'(d), 16'(e));
      end
      m.stop();
      // Realign so that the next input change lands 3.3 ns after a falling edge
      @(negedge sys_clk);
   endtask

   task automatic give_verdict();
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // About 59k cycles expected; this 100k-cycle limit leaves a margin of about 40k
   initial begin
      #1000000;
      errors++;
      give_verdict();
   end

   initial begin
      int p;
      nrst = 1'b0;
      lock = 2'h0;
      ain = 2'h0;
      meas = '0;
      seed = 32'h43b5;
      errors = 0;
      compares = 0;
      function_command_byte_n = 0;
      fexp = 0;
      init_model();
      repeat (4) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (8) @(negedge sys_clk);
      probe(7'h37, 1'b0);
      probe(ras_pkg::SLAVE_ADDR, 1'b1);
      rseq(1, 1);
      for (int i = 0; i < 8; i++) meas[8*i +: 8] = rnd();
      ain = 2'(rnd());
      rseq(8, 8);
      wseq(1, 1, 8);
      rseq(1, 2);
      lock = 2'h2;
      wseq(8'h2e, 4, 8);
      lock = 2'h1;
      wseq(8'h2e, 4, 8);
      wseq(8'h3e, 4, 8);
      rseq(8'h2e, 4);
      wseq(8'h61, 2, 8);
      wseq(8'h4e, 3, 8);
      wseq(8'h08, 2, 8);
      wseq(8'hfe, 1, 8);
      wseq(8'hfd, 2, 8);
      wseq(8'h10, 3, 4);
      rseq(8'h60, 3);
      rseq(8'hff, 3);
      // Random places, lengths and locks
      repeat (6) begin
         lock = 2'(rnd());
         p = int'(rnd()) % 8'h70;
         wseq(p, 1 + int'(rnd()) % 3, 8);
         rseq(p, 3);
      end
      nrst = 1'b0;
      repeat (4) @(negedge sys_clk);
      nrst = 1'b1;
      init_model();
      repeat (8) @(negedge sys_clk);
      rseq(1, 1);
      give_verdict();
   end
endmodule
